//--- hdl/sdo_expedited_server.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Function
// R01: Every accepted request gets exactly one reply frame; an accepted abort request gets no reply here.
// R02: Byte 0 command, bytes 1-2 index, byte 3 subindex, bytes 4-7 data.
// R03: Download writes the dictionary; upload reads it.
// R04: Serve initiate/segment download, initiate/segment upload and abort; segment requests get abort code 0x05040001 here.
// R05: Expedited flag set means bytes 4-7 carry data directly.
// R06: Size flag tells length is given; both flags clear is reserved.
// R07: Unused byte count valid only with both flags set, else zero.
// R08: Normal sized transfer carries a byte counter, LSB in byte 4.
// R09: Master reads with command 0x40, other data bytes zero.
// R10: Read reply 0x4F, 0x4B or 0x43 for one, two or four bytes.
// R11: Unservable read answers with command 0x80.
// R12: Master writes with 0x2F, 0x2B or 0x23 by length.
// R13: Accepted write is confirmed with command 0x60.
// R14: Failed write answers 0x80 plus an error code.
// R15: Abort codes for bad command, missing index, bad subindex.
// R16: Abort codes for reading write-only, writing read-only objects.
// R17: Abort codes for length mismatch, too large, too short.
// R18: Abort codes for out-of-range, too much, too little data.
// R19: Abort codes for fault state and forbidding device state.
// R20: Abort code for mapping a non-mappable parameter.
// R21: Request id 0x600+station, reply 0x580+station, eight bytes, echo index.
// R22: Station number is 1 to 127; zero is never used.
// R23: Abort reply echoes index and carries code LSB first in bytes 4-7.
// ---------------------------------------------------------------
module sdo_expedited_server (
    input wire logic core_clk, // System clock
    input wire logic rstn, // Async reset, active low
    input wire logic [6:0] station_number, // Own station address
    input wire logic rx_valid, // Received frame strobe
    input wire logic [10:0] rx_id, // Received identifier
    input wire logic [3:0] rx_dlc, // Received length
    input wire logic [63:0] rx_data, // Received bytes, byte 0 at [7:0]
    output logic rx_ready_ff, // Server can take a frame
    output logic od_req_ff, // Dictionary access strobe
    output logic od_write_ff, // Access is a write
    output logic [15:0] od_index_ff, // Object index
    output logic [7:0] od_sub_ff, // Object subindex
    output logic [31:0] od_wdata_ff, // Write value
    output logic [2:0] od_wlen_ff, // Write length in bytes
    input wire logic od_ack, // Dictionary answer strobe
    input wire logic [2:0] od_status, // Lookup status code
    input wire logic [1:0] od_attr, // Read/write permission bits
    input wire logic [2:0] od_size, // Object size in bytes
    input wire logic [31:0] od_rdata, // Read value
    input wire logic drive_fault, // Drive in error-fault state
    output logic tx_valid_ff, // Reply frame valid
    output logic [10:0] tx_id_ff, // Reply identifier
    output logic [3:0] tx_dlc_ff, // Reply length
    output logic [63:0] tx_data_ff, // Reply bytes
    input wire logic tx_ready, // Reply taken
    output logic bad_station_ff // Station number out of range
);
    localparam logic [3:0] FRAME_LEN = 4'h8;
    localparam logic [31:0] MAX_EXP_LEN = 32'h0000_0004; // Longest single-frame payload

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // Reply frame from command, echoed address and payload
    function automatic logic [63:0] pack_frame(input logic [7:0] cmd, input logic [15:0] idx,
                                               input logic [7:0] sub, input logic [31:0] dat);
        pack_frame = {dat, sub, idx, cmd}; // see R02 see R23
    endfunction

    // Read reply command byte for an object size
    function automatic logic [7:0] up_cmd(input logic [2:0] len);
        unique case (len)
            3'h1: up_cmd = sdo_pkg::REP_UP_1;
            3'h2: up_cmd = sdo_pkg::REP_UP_2;
            3'h3: up_cmd = sdo_pkg::REP_UP_3;
            default: up_cmd = sdo_pkg::REP_UP_4;
        endcase
    endfunction

    // Lookup status to abort code
    function automatic logic [31:0] od_code(input logic [2:0] st);
        unique case (st)
            sdo_pkg::OD_NO_INDEX: od_code = sdo_pkg::AB_INDEX;
            sdo_pkg::OD_NO_SUB: od_code = sdo_pkg::AB_SUBIDX;
            sdo_pkg::OD_NO_MAP: od_code = sdo_pkg::AB_NOMAP;
            sdo_pkg::OD_RANGE: od_code = sdo_pkg::AB_RANGE;
            default: od_code = sdo_pkg::AB_STATE;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // Request decode
    // ---------------------------------------------------------------
    logic [7:0] rq_cmd;
    logic [2:0] rq_ccs;
    logic rq_e;
    logic rq_s;
    logic [1:0] rq_n;
    logic [2:0] rq_len;
    logic addressed;
    logic station_ok;
    assign rq_cmd = rx_data[7:0];
    assign rq_ccs = rq_cmd[sdo_pkg::CCS_HI:sdo_pkg::CCS_LO];
    assign rq_e = rq_cmd[sdo_pkg::E_BIT]; // see R05
    assign rq_s = rq_cmd[sdo_pkg::S_BIT]; // see R06
    // Unused count only counts with both flags set
    assign rq_n = (rq_e && rq_s) ? rq_cmd[sdo_pkg::N_HI:sdo_pkg::N_LO] : 2'h0; // see R07
    assign rq_len = sdo_pkg::LEN_FOUR - {1'b0, rq_n};
    assign station_ok = (station_number >= sdo_pkg::STATION_MIN); // see R22
    // Frames for another station or short frames are not ours
    assign addressed = station_ok && (rx_id == sdo_pkg::REQ_BASE_ID + {4'h0, station_number})
                       && (rx_dlc == FRAME_LEN); // see R21

    // ---------------------------------------------------------------
    // State and captured request
    // ---------------------------------------------------------------
    sdo_pkg::sdo_state_t state_ff;
    sdo_pkg::sdo_state_t nxt_state;
    logic [15:0] idx_ff;
    logic [7:0] sub_ff;
    logic is_wr_ff;
    logic [2:0] len_ff;
    logic chk_fail_ff;
    logic [31:0] chk_code_ff;
    logic take;
    assign take = (state_ff == sdo_pkg::SDO_IDLE) && rx_valid && addressed;

    // Static checks done on capture, before the dictionary is asked
    logic pre_fail;
    logic [31:0] pre_code;
    always_comb begin
        pre_fail = 1'b1;
        pre_code = sdo_pkg::AB_CMD; // see R15
        unique case (rq_ccs)
            sdo_pkg::CCS_DN_INIT: begin
                if (!rq_e && !rq_s) begin
                    pre_code = sdo_pkg::AB_CMD; // Reserved combination, see R06
                end else if (!rq_e) begin
                    // Normal transfer: byte counter, segments unsupported, see R08
                    pre_code = (rx_data[63:32] > MAX_EXP_LEN) ? sdo_pkg::AB_TOO_MANY
                               : sdo_pkg::AB_LEN; // see R18 see R17
                end else if (drive_fault) begin
                    pre_code = sdo_pkg::AB_FAULT; // see R19
                end else begin
                    pre_fail = 1'b0;
                end
            end
            sdo_pkg::CCS_UP_INIT: begin
                pre_code = sdo_pkg::AB_FAULT; // see R19
                pre_fail = drive_fault; // see R03
            end
            default: begin
                pre_fail = 1'b1; // Segment services without a transfer, see R04
            end
        endcase
    end

    // Main sequence: idle, dictionary lookup, wait answer, send reply
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            sdo_pkg::SDO_IDLE: begin
                if (take && rq_ccs != sdo_pkg::CCS_ABORT) begin
                    nxt_state = pre_fail ? sdo_pkg::SDO_SEND : sdo_pkg::SDO_LOOK;
                end
            end
            sdo_pkg::SDO_LOOK: nxt_state = sdo_pkg::SDO_WAIT;
            sdo_pkg::SDO_WAIT: if (od_ack) nxt_state = sdo_pkg::SDO_SEND;
            sdo_pkg::SDO_SEND: if (tx_ready && tx_valid_ff) nxt_state = sdo_pkg::SDO_IDLE;
        endcase
    end

    // State register; an abort request ends silently, it needs no reply
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= sdo_pkg::SDO_IDLE;
        end else begin
            state_ff <= nxt_state; // see R01
        end
    end

    // Capture request fields
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            idx_ff <= 16'h0000;
            sub_ff <= 8'h00;
            is_wr_ff <= 1'b0;
            len_ff <= sdo_pkg::LEN_FOUR;
            chk_fail_ff <= 1'b0;
            chk_code_ff <= 32'h0000_0000;
        end else if (take) begin
            idx_ff <= rx_data[23:8]; // see R02
            sub_ff <= rx_data[31:24];
            is_wr_ff <= (rq_ccs == sdo_pkg::CCS_DN_INIT); // see R03
            len_ff <= rq_s ? rq_len : sdo_pkg::LEN_FOUR;
            chk_fail_ff <= pre_fail;
            chk_code_ff <= pre_code;
        end
    end

    // ---------------------------------------------------------------
    // Dictionary port
    // ---------------------------------------------------------------
    // One-cycle request in the lookup state
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            od_req_ff <= 1'b0;
            od_write_ff <= 1'b0;
            od_index_ff <= 16'h0000;
            od_sub_ff <= 8'h00;
            od_wdata_ff <= 32'h0000_0000;
            od_wlen_ff <= 3'h0;
        end else begin
            od_req_ff <= take && !pre_fail && rq_ccs != sdo_pkg::CCS_ABORT;
            if (take) begin
                od_write_ff <= (rq_ccs == sdo_pkg::CCS_DN_INIT);
                od_index_ff <= rx_data[23:8];
                od_sub_ff <= rx_data[31:24];
                od_wdata_ff <= rx_data[63:32]; // Expedited data direct, see R05
                od_wlen_ff <= rq_s ? rq_len : sdo_pkg::LEN_FOUR;
            end
        end
    end

    // ---------------------------------------------------------------
    // Reply build
    // ---------------------------------------------------------------
    logic [7:0] rp_cmd;
    logic [31:0] rp_data;
    logic [2:0] rd_len;
    // First failing check wins; sizes 0 or above 4 read as four bytes
    always_comb begin
        rd_len = (od_size == 3'h0 || od_size > sdo_pkg::LEN_FOUR) ? sdo_pkg::LEN_FOUR : od_size;
        rp_cmd = sdo_pkg::REP_ABORT;
        rp_data = 32'h0000_0000;
        if (od_status != sdo_pkg::OD_OK) begin
            rp_data = od_code(od_status); // see R15 see R18 see R19 see R20
        end else if (!is_wr_ff && !od_attr[sdo_pkg::ATTR_RD]) begin
            rp_data = sdo_pkg::AB_WO; // see R16
        end else if (is_wr_ff && !od_attr[sdo_pkg::ATTR_WR]) begin
            rp_data = sdo_pkg::AB_RO; // see R16
        end else if (is_wr_ff && len_ff > od_size) begin
            rp_data = sdo_pkg::AB_LEN_HI; // see R17
        end else if (is_wr_ff && len_ff < od_size) begin
            rp_data = sdo_pkg::AB_LEN_LO; // see R17
        end else if (is_wr_ff) begin
            rp_cmd = sdo_pkg::REP_DN_OK; // see R13
        end else begin
            rp_cmd = up_cmd(rd_len); // see R10
            rp_data = od_rdata;
        end
    end

    // Reply frame register; held until taken
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tx_valid_ff <= 1'b0;
            tx_id_ff <= sdo_pkg::REP_BASE_ID;
            tx_dlc_ff <= FRAME_LEN;
            tx_data_ff <= 64'h0000_0000_0000_0000;
        end else if (tx_valid_ff) begin
            if (tx_ready) tx_valid_ff <= 1'b0;
        end else if (state_ff == sdo_pkg::SDO_WAIT && od_ack) begin
            tx_valid_ff <= 1'b1; // see R01
            tx_id_ff <= sdo_pkg::REP_BASE_ID + {4'h0, station_number}; // see R21
            tx_dlc_ff <= FRAME_LEN;
            tx_data_ff <= pack_frame(rp_cmd, idx_ff, sub_ff, rp_data); // see R11 see R14
        end else if (state_ff == sdo_pkg::SDO_SEND) begin
            tx_valid_ff <= 1'b1;
            tx_id_ff <= sdo_pkg::REP_BASE_ID + {4'h0, station_number};
            tx_dlc_ff <= FRAME_LEN;
            tx_data_ff <= pack_frame(sdo_pkg::REP_ABORT, idx_ff, sub_ff, chk_code_ff); // see R23
        end
    end

    // Ready and station status
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rx_ready_ff <= 1'b0;
            bad_station_ff <= 1'b0;
        end else begin
            rx_ready_ff <= (nxt_state == sdo_pkg::SDO_IDLE);
            bad_station_ff <= !station_ok; // see R22
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    // Abort requests are left out: that service is never confirmed
    sequence s_take_req;
        take && rq_ccs != sdo_pkg::CCS_ABORT;
    endsequence

    sequence s_reply;
        tx_valid_ff;
    endsequence

    chk_one_reply: assert property (@(posedge core_clk) disable iff (!rstn) // see R01
        s_take_req |-> ##[1:1000] s_reply)
        else $error("request without reply");
    chk_reply_id: assert property (@(posedge core_clk) disable iff (!rstn) // see R21
        tx_valid_ff |-> tx_id_ff == sdo_pkg::REP_BASE_ID + {4'h0, station_number}
                        && tx_dlc_ff == FRAME_LEN)
        else $error("reply identifier wrong");
    chk_echo_index: assert property (@(posedge core_clk) disable iff (!rstn) // see R23
        tx_valid_ff |-> tx_data_ff[31:8] == {sub_ff, idx_ff})
        else $error("reply index not echoed");
    chk_reserved_abort: assert property (@(posedge core_clk) disable iff (!rstn) // see R06
        (take && rq_ccs == sdo_pkg::CCS_DN_INIT && !rq_e && !rq_s)
        |-> ##2 tx_valid_ff && tx_data_ff[63:32] == sdo_pkg::AB_CMD)
        else $error("reserved flags not aborted");
    chk_write_ok: assert property (@(posedge core_clk) disable iff (!rstn) // see R13
        (tx_valid_ff && is_wr_ff && tx_data_ff[7:0] != sdo_pkg::REP_ABORT)
        |-> tx_data_ff[7:0] == sdo_pkg::REP_DN_OK)
        else $error("write confirm byte wrong");
    chk_fault_abort: assert property (@(posedge core_clk) disable iff (!rstn) // see R19
        (take && rq_ccs == sdo_pkg::CCS_UP_INIT && drive_fault)
        |-> ##2 tx_data_ff[63:32] == sdo_pkg::AB_FAULT)
        else $error("fault state not aborted");
    chk_ro_abort: assert property (@(posedge core_clk) disable iff (!rstn) // see R16
        (state_ff == sdo_pkg::SDO_WAIT && od_ack && !tx_valid_ff && is_wr_ff
         && od_status == sdo_pkg::OD_OK && !od_attr[sdo_pkg::ATTR_WR])
        |=> tx_data_ff[63:32] == sdo_pkg::AB_RO && tx_data_ff[7:0] == sdo_pkg::REP_ABORT)
        else $error("read-only write not aborted");
    chk_index_abort: assert property (@(posedge core_clk) disable iff (!rstn) // see R15
        (state_ff == sdo_pkg::SDO_WAIT && od_ack && !tx_valid_ff
         && od_status == sdo_pkg::OD_NO_INDEX)
        |=> tx_data_ff[63:32] == sdo_pkg::AB_INDEX)
        else $error("missing index not aborted");
    chk_read_cmd: assert property (@(posedge core_clk) disable iff (!rstn) // see R10
        (state_ff == sdo_pkg::SDO_WAIT && od_ack && !tx_valid_ff && !is_wr_ff
         && od_status == sdo_pkg::OD_OK && od_attr[sdo_pkg::ATTR_RD] && od_size == 3'h1)
        |=> tx_data_ff[7:0] == sdo_pkg::REP_UP_1)
        else $error("read reply byte wrong");
    chk_station_zero: assert property (@(posedge core_clk) disable iff (!rstn) // see R22
        (station_number == 7'h00) |-> !take ##1 bad_station_ff)
        else $error("station zero accepted");

    chk_abort_quiet: assert property (@(posedge core_clk) disable iff (!rstn) // see R04
        (take && rq_ccs == sdo_pkg::CCS_ABORT) |=> !od_req_ff ##1 !tx_valid_ff)
        else $error("abort request answered");
endmodule // sdo_expedited_server

//--- hdl/sdo_pkg.sv
package sdo_pkg;
    // Frame identifiers
    localparam logic [10:0] REQ_BASE_ID = 11'h600;
    localparam logic [10:0] REP_BASE_ID = 11'h580;
    localparam logic [6:0] STATION_MIN = 7'h01;
    localparam logic [6:0] STATION_MAX = 7'h7f;
    // Command byte field positions
    localparam int CCS_HI = 7;
    localparam int CCS_LO = 5;
    localparam int N_HI = 3;
    localparam int N_LO = 2;
    localparam int E_BIT = 1;
    localparam int S_BIT = 0;
    // Client command specifiers (bits 7..5)
    localparam logic [2:0] CCS_DN_SEG = 3'h0;
    localparam logic [2:0] CCS_DN_INIT = 3'h1;
    localparam logic [2:0] CCS_UP_INIT = 3'h2;
    localparam logic [2:0] CCS_UP_SEG = 3'h3;
    localparam logic [2:0] CCS_ABORT = 3'h4;
    // Reply command bytes
    localparam logic [7:0] REP_UP_1 = 8'h4f;
    localparam logic [7:0] REP_UP_2 = 8'h4b;
    localparam logic [7:0] REP_UP_3 = 8'h47;
    localparam logic [7:0] REP_UP_4 = 8'h43;
    localparam logic [7:0] REP_DN_OK = 8'h60;
    localparam logic [7:0] REP_ABORT = 8'h80;
    localparam logic [7:0] REP_DN_SEG = 8'h20;
    localparam logic [7:0] REP_UP_SEG = 8'h00;
    localparam logic [7:0] REP_UP_NORM = 8'h41;
    // Abort codes
    localparam logic [31:0] AB_CMD = 32'h0504_0001;
    localparam logic [31:0] AB_WO = 32'h0601_0001;
    localparam logic [31:0] AB_RO = 32'h0601_0002;
    localparam logic [31:0] AB_INDEX = 32'h0602_0000;
    localparam logic [31:0] AB_NOMAP = 32'h0604_0041;
    localparam logic [31:0] AB_FAULT = 32'h0606_0000;
    localparam logic [31:0] AB_LEN = 32'h0607_0010;
    localparam logic [31:0] AB_LEN_HI = 32'h0607_0012;
    localparam logic [31:0] AB_LEN_LO = 32'h0607_0013;
    localparam logic [31:0] AB_SUBIDX = 32'h0609_0011;
    localparam logic [31:0] AB_RANGE = 32'h0609_0030;
    localparam logic [31:0] AB_TOO_MANY = 32'h0609_0031;
    localparam logic [31:0] AB_TOO_FEW = 32'h0609_0032;
    localparam logic [31:0] AB_STATE = 32'h0800_0022;
    // Dictionary lookup status codes
    localparam logic [2:0] OD_OK = 3'h0;
    localparam logic [2:0] OD_NO_INDEX = 3'h1;
    localparam logic [2:0] OD_NO_SUB = 3'h2;
    localparam logic [2:0] OD_NO_MAP = 3'h3;
    localparam logic [2:0] OD_RANGE = 3'h4;
    localparam logic [2:0] OD_STATE = 3'h5;
    // Access attribute bits
    localparam int ATTR_RD = 0;
    localparam int ATTR_WR = 1;
    localparam logic [2:0] LEN_ONE = 3'h1;
    localparam logic [2:0] LEN_FOUR = 3'h4;
    // Server state machine, one-hot
    typedef enum logic [3:0] {
        SDO_IDLE = 4'b0001,
        SDO_LOOK = 4'b0010,
        SDO_WAIT = 4'b0100,
        SDO_SEND = 4'b1000
    } sdo_state_t;
endpackage

//--- sim/sdo_od_model.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Dictionary responder behind the server's lookup port
// ---------------------------------------------------------------
module sdo_od_model (
    input wire logic core_clk, // System clock
    input wire logic rstn, // Async reset, active low
    input wire logic od_req, // Lookup strobe
    input wire logic [15:0] od_index, // Object index
    input wire logic [7:0] od_sub, // Object subindex
    input wire logic [3:0] dly, // Extra answer delay in cycles
    output logic od_ack, // Answer strobe
    output logic [2:0] od_status, // Lookup status
    output logic [1:0] od_attr, // Permission bits
    output logic [2:0] od_size, // Object size in bytes
    output logic [31:0] od_rdata // Read value
);
    logic [4:0] cnt_ff;
    logic [2:0] st;
    logic [1:0] at;
    logic [2:0] sz;
    logic [31:0] rd;
    // Countdown to the answer, so slow lookups get exercised too
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_ff <= 5'h00;
        end else if (od_req) begin
            cnt_ff <= {1'b0, dly} + 5'h01;
        end else if (cnt_ff != 5'h00) begin
            cnt_ff <= cnt_ff - 5'h01;
        end
    end
    // Small object table; unknown indices report a missing object
    always_comb begin
        case (od_index)
            16'h6040: {st, at, sz, rd} = {sdo_pkg::OD_OK, 2'h3, 3'h2, 32'h0000_1234};
            16'h6060: {st, at, sz, rd} = {sdo_pkg::OD_OK, 2'h3, 3'h1, 32'h0000_0003};
            16'h6083: {st, at, sz, rd} = {sdo_pkg::OD_OK, 2'h3, 3'h4, 32'h0001_a36e};
            16'h607a: {st, at, sz, rd} = {sdo_pkg::OD_OK, 2'h2, 3'h4, 32'h0000_0000};
            16'h6041: {st, at, sz, rd} = {sdo_pkg::OD_OK, 2'h1, 3'h2, 32'h0000_0237};
            16'h1a00: {st, at, sz, rd} = {sdo_pkg::OD_NO_MAP, 2'h3, 3'h4, 32'h0000_0000};
            16'h6065: {st, at, sz, rd} = {sdo_pkg::OD_RANGE, 2'h3, 3'h4, 32'h0000_0000};
            16'h6066: {st, at, sz, rd} = {sdo_pkg::OD_STATE, 2'h3, 3'h4, 32'h0000_0000};
            default: {st, at, sz, rd} = {sdo_pkg::OD_NO_INDEX, 2'h3, 3'h4, 32'h0000_0000};
        endcase
        if (od_sub != 8'h00 && st == sdo_pkg::OD_OK) begin
            st = sdo_pkg::OD_NO_SUB;
        end
    end
    // Junk outside the strobe, so a late sample cannot pass by luck
    assign od_ack = (cnt_ff == 5'h01);
    assign od_status = od_ack ? st : ~st;
    assign od_attr = od_ack ? at : ~at;
    assign od_size = od_ack ? sz : ~sz;
    assign od_rdata = od_ack ? rd : ~rd;
endmodule // sdo_od_model

//--- sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    typedef struct packed {
        logic [7:0] cmd;
        logic [15:0] idx;
        logic [7:0] sub;
        logic [31:0] dat;
        logic flt;
        logic [7:0] rcmd;
        logic [31:0] rdat;
    } sdo_case_t;
    logic core_clk, rstn, rx_valid, tx_ready, drive_fault, od_ack;
    logic rx_ready_ff, od_req_ff, od_write_ff, tx_valid_ff, bad_station_ff;
    logic [6:0] station_number;
    logic [10:0] rx_id, tx_id_ff;
    logic [3:0] rx_dlc, dly, tx_dlc_ff;
    logic [63:0] rx_data, tx_data_ff;
    logic [15:0] od_index_ff;
    logic [7:0] od_sub_ff;
    logic [31:0] od_wdata_ff, od_rdata;
    logic [2:0] od_wlen_ff, od_status, od_size;
    logic [1:0] od_attr;
    int miscompares = 0;
    int total_checks = 0;
    // Request, expected reply command and expected reply data
    sdo_case_t tbl [0:19] = '{
        '{8'h40, 16'h6040, 8'h0, 32'h0, 1'h0, 8'h4b, 32'h1234},
        '{8'h40, 16'h6060, 8'h0, 32'h0, 1'h0, 8'h4f, 32'h3},
        '{8'h40, 16'h6083, 8'h0, 32'h0, 1'h0, 8'h43, 32'h1_a36e},
        '{8'h40, 16'h607a, 8'h0, 32'h0, 1'h0, 8'h80, 32'h0601_0001},
        '{8'h2b, 16'h6041, 8'h0, 32'h5, 1'h0, 8'h80, 32'h0601_0002},
        '{8'h2f, 16'h6060, 8'h0, 32'h3, 1'h0, 8'h60, 32'h0},
        '{8'h23, 16'h607a, 8'h0, 32'hffe4_b17e, 1'h0, 8'h60, 32'h0},
        '{8'h2b, 16'h6040, 8'h0, 32'h2f, 1'h0, 8'h60, 32'h0},
        '{8'h40, 16'h2000, 8'h0, 32'h0, 1'h0, 8'h80, 32'h0602_0000},
        '{8'h40, 16'h6040, 8'h1, 32'h0, 1'h0, 8'h80, 32'h0609_0011},
        '{8'h60, 16'h6040, 8'h0, 32'h0, 1'h0, 8'h80, 32'h0504_0001},
        '{8'h20, 16'h6040, 8'h0, 32'h0, 1'h0, 8'h80, 32'h0504_0001},
        '{8'h23, 16'h6040, 8'h0, 32'h0, 1'h0, 8'h80, 32'h0607_0012},
        '{8'h2f, 16'h6040, 8'h0, 32'h0, 1'h0, 8'h80, 32'h0607_0013},
        '{8'h21, 16'h6040, 8'h0, 32'h8, 1'h0, 8'h80, 32'h0609_0031},
        '{8'h21, 16'h6040, 8'h0, 32'h2, 1'h0, 8'h80, 32'h0607_0010},
        '{8'h23, 16'h1a00, 8'h0, 32'h0, 1'h0, 8'h80, 32'h0604_0041},
        '{8'h23, 16'h6065, 8'h0, 32'h0, 1'h0, 8'h80, 32'h0609_0030},
        '{8'h23, 16'h6066, 8'h0, 32'h0, 1'h0, 8'h80, 32'h0800_0022},
        '{8'h40, 16'h6040, 8'h0, 32'h0, 1'h1, 8'h80, 32'h0606_0000}
    };
    sdo_expedited_server dut (.core_clk(core_clk), .rstn(rstn), .station_number(station_number),
        .rx_valid(rx_valid), .rx_id(rx_id), .rx_dlc(rx_dlc), .rx_data(rx_data),
        .rx_ready_ff(rx_ready_ff), .od_req_ff(od_req_ff), .od_write_ff(od_write_ff),
        .od_index_ff(od_index_ff), .od_sub_ff(od_sub_ff), .od_wdata_ff(od_wdata_ff),
        .od_wlen_ff(od_wlen_ff), .od_ack(od_ack), .od_status(od_status), .od_attr(od_attr),
        .od_size(od_size), .od_rdata(od_rdata), .drive_fault(drive_fault),
        .tx_valid_ff(tx_valid_ff), .tx_id_ff(tx_id_ff), .tx_dlc_ff(tx_dlc_ff),
        .tx_data_ff(tx_data_ff), .tx_ready(tx_ready), .bad_station_ff(bad_station_ff));
    sdo_od_model od (.core_clk(core_clk), .rstn(rstn), .od_req(od_req_ff),
        .od_index(od_index_ff), .od_sub(od_sub_ff), .dly(dly), .od_ack(od_ack),
        .od_status(od_status), .od_attr(od_attr), .od_size(od_size), .od_rdata(od_rdata));
    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [63:0] frm(input logic [7:0] c, input logic [15:0] i,
                                        input logic [7:0] s, input logic [31:0] d);
        return {d, s, i, c};
    endfunction
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Offers one frame once the server is idle, held for a single edge
    task automatic send(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] d);
        int n;
        n = 0;
        while (rx_ready_ff !== 1'b1 && n < 50) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        @(posedge core_clk);
        rx_valid <= 1'b1;
        rx_id <= id;
        rx_dlc <= dlc;
        rx_data <= d;
        @(posedge core_clk);
        rx_valid <= 1'b0;
        rx_data <= ~d;
        #1;
    endtask
    // Master stalls until the reply shows, compares it, then takes it
    task automatic xfer(input logic [63:0] req, input logic [63:0] exp);
        int n;
        n = 0;
        send(11'(sdo_pkg::REQ_BASE_ID + station_number), 4'h8, req);
        while (tx_valid_ff !== 1'b1 && n < 60) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk(64'(tx_id_ff), 64'(11'(sdo_pkg::REP_BASE_ID + station_number)));
        chk(64'(tx_dlc_ff), 64'h8);
        chk(tx_data_ff, exp);
        @(posedge core_clk);
        tx_ready <= 1'b1;
        @(posedge core_clk);
        tx_ready <= 1'b0;
        #1;
        chk(64'({tx_valid_ff, rx_ready_ff}), 64'h1);
    endtask
    // Frame that must draw neither a reply nor a lookup
    task automatic quiet(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] d);
        int seen;
        seen = 0;
        send(id, dlc, d);
        repeat (12) begin
            @(posedge core_clk);
            #1;
            if (tx_valid_ff !== 1'b0 || od_req_ff !== 1'b0) seen++;
        end
        chk(64'(seen), 64'h0);
    endtask
    // ---------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ---------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // About 25 transfers of under 60 cycles each; generous margin
    initial begin
        #200000;
        miscompares++;
        test_done();
    end
    initial begin
        {rstn, rx_valid, tx_ready, drive_fault} = 4'h0;
        {rx_id, rx_dlc, rx_data, dly} = '0;
        station_number = 7'h05;
        repeat (10) @(posedge core_clk);
        #1;
        chk(64'({tx_valid_ff, tx_dlc_ff, tx_id_ff}), 64'h4580);
        @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        #1;
        foreach (tbl[i]) begin
            dly <= 4'((i * 5) % 11);
            drive_fault <= tbl[i].flt;
            xfer(frm(tbl[i].cmd, tbl[i].idx, tbl[i].sub, tbl[i].dat),
                 frm(tbl[i].rcmd, tbl[i].idx, tbl[i].sub, tbl[i].rdat));
            if (tbl[i].rcmd == 8'h60) chk(64'({od_write_ff, od_wlen_ff, od_wdata_ff}),
                {29'h1, 3'(3'h4 - tbl[i].cmd[3:2]), tbl[i].dat});
        end
        drive_fault <= 1'b0;
        quiet(11'h605, 4'h8, frm(8'h80, 16'h6040, 8'h0, 32'h0601_0000));
        quiet(11'h606, 4'h8, frm(8'h40, 16'h6040, 8'h0, 32'h0));
        quiet(11'h605, 4'h7, frm(8'h40, 16'h6040, 8'h0, 32'h0));
        station_number <= 7'h7f;
        @(posedge core_clk);
        xfer(frm(8'h40, 16'h6040, 8'h0, 32'h0), frm(8'h4b, 16'h6040, 8'h0, 32'h1234));
        chk(64'(bad_station_ff), 64'h0);
        station_number <= 7'h00;
        repeat (2) @(posedge core_clk);
        #1;
        chk(64'(bad_station_ff), 64'h1);
        quiet(11'h600, 4'h8, frm(8'h40, 16'h6040, 8'h0, 32'h0));
        test_done();
    end
endmodule // tb_top
